// ---- inc/tsf_pkg.sv ----
// Shared constants and types for the trace and severe fault unit.
package tsf_pkg;
  localparam logic [4:0] TSF_IPL_MAX = 5'h1F;
  localparam logic [4:0] TSF_IPL_RESET = 5'h1F;
  localparam logic [7:0] TSF_VEC_MCHK = 8'h04;
  localparam logic [7:0] TSF_VEC_KSNV = 8'h08;
  localparam logic [7:0] TSF_VEC_TRACE = 8'h28;
  localparam logic [1:0] TSF_VEC_LOW_ISTK = 2'h1;
  localparam logic [3:0] TSF_HALT_NONE = 4'h0;
  localparam logic [3:0] TSF_HALT_ISNV = 4'h1;
  localparam logic [3:0] TSF_HALT_MEMERR = 4'h2;
  localparam int TSF_MCHK_WORDS = 4;
  localparam int TSF_BYTES_PER_WORD = 4;
  localparam logic [31:0] TSF_WORD_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    TSF_FR_NONE,
    TSF_FR_EXC,
    TSF_FR_CHM,
    TSF_FR_TRACE,
    TSF_FR_KSNV,
    TSF_FR_MCHK
  } tsf_frame_t;
endpackage

// ---- logic/tsf_halt_regs.sv ----
// Holding registers for program counter, status and reason at a halt.
`timescale 1ns/1ps
`default_nettype none
module tsf_halt_regs (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_capture,
  input wire logic [31:0] i_pc,
  input wire logic [31:0] i_psl,
  input wire logic [3:0] i_reason,
  output logic [31:0] o_pc,
  output logic [31:0] o_psl,
  output logic [3:0] o_reason
);
  import tsf_pkg::*;

  // Values stay until the next halt so a debugger can read them after a boot.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pc <= TSF_WORD_RESET;
      o_psl <= TSF_WORD_RESET;
      o_reason <= TSF_HALT_NONE;
    end else if (i_capture) begin
      o_pc <= i_pc;
      o_psl <= i_psl;
      o_reason <= i_reason;
    end
  end
endmodule
`default_nettype wire

// ---- logic/tsf_mchk_frame.sv ----
// Machine-check frame streamer: count, error report words, PC, status.
`timescale 1ns/1ps
`default_nettype none
module tsf_mchk_frame #(
  parameter int WORDS = tsf_pkg::TSF_MCHK_WORDS
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [31:0] i_pc,
  input wire logic [31:0] i_psl,
  input wire logic [31:0] i_err_word,
  input wire logic i_ready,
  output logic o_valid,
  output logic [31:0] o_data,
  output logic o_last,
  output logic [7:0] o_err_idx
);
  import tsf_pkg::*;

  localparam logic [7:0] LAST_IDX = 8'(WORDS + 2);
  localparam logic [31:0] COUNT_BYTES = 32'(WORDS * TSF_BYTES_PER_WORD);
  logic [7:0] idx_r;
  logic [31:0] pc_r;
  logic [31:0] psl_r;
  logic [31:0] word_nxt;

  assign o_last = o_valid && (idx_r == LAST_IDX);
  assign o_err_idx = idx_r;

  always_comb begin
    if (idx_r < 8'(WORDS)) begin
      word_nxt = i_err_word;
    end else if (idx_r == 8'(WORDS)) begin
      word_nxt = pc_r;
    end else begin
      word_nxt = psl_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_valid <= 1'b0;
      idx_r <= 8'h00;
      o_data <= TSF_WORD_RESET;
      pc_r <= TSF_WORD_RESET;
      psl_r <= TSF_WORD_RESET;
    end else if (i_start) begin
      o_valid <= 1'b1;
      idx_r <= 8'h00;
      o_data <= COUNT_BYTES;
      pc_r <= i_pc;
      psl_r <= i_psl;
    end else if (o_valid && i_ready) begin
      if (o_last) begin
        o_valid <= 1'b0;
      end else begin
        idx_r <= idx_r + 8'h01;
        o_data <= word_nxt;
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/tsf_unit.sv ----
// Trace status bits, trace faults and the severe fault paths of the processor.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Interrupts and exceptions stack trace bits unchanged, then clear both.
// - Change-mode trap clears both; stacked pending equals the old enable.
// - Pending trace at return or change-mode gives a trace fault instead.
// - A trace fault preempting a return leaves the original stacked status alone.
// - Return restores enable; pending becomes stacked pending OR current enable.
// - Traced routine returning to traced program yields only one trace.
// - Enable restored by procedure return resumes tracing after the next instruction.
// - Kernel stack invalid during frame push becomes abort on interrupt stack, level 1F.
// - Kernel stack invalid during normal instruction raises memory-management fault.
// - Interrupt stack invalid or memory error during frame push halts.
// - While halted, no interrupt request is acknowledged.
// - Halt keeps program counter, status and reason in readable registers.
// - An optional watchdog boot can leave the halted state.
// - Internal errors take machine check at any level, interrupt stack, level 1F.
// - Machine-check frame: byte count, error report words, then PC and status.
// - Bus, memory and other processor errors all go through machine check.
// - State after uncertain errors is preserved on a best-effort basis.
// - Each instruction end sets pending if enable was set at its start.
// - Between instructions a pending trace fault precedes all other exceptions.
module tsf_unit #(
  parameter int MCHK_WORDS = tsf_pkg::TSF_MCHK_WORDS
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_instr_start,
  input wire logic i_instr_end,
  input wire logic i_boundary,
  input wire logic i_rei,
  input wire logic i_rei_stk_t,
  input wire logic i_rei_stk_tp,
  input wire logic [4:0] i_rei_ipl,
  input wire logic i_chm,
  input wire logic i_ret,
  input wire logic i_ret_t,
  input wire logic i_exc_req,
  input wire logic i_exc_istk,
  input wire logic i_irq_req,
  input wire logic [4:0] i_irq_ipl,
  input wire logic [31:0] i_pc,
  input wire logic [31:0] i_psl,
  input wire logic i_push_done,
  input wire logic i_push_kstk_inval,
  input wire logic i_push_istk_inval,
  input wire logic i_push_mem_err,
  input wire logic i_kstk_inval_instr,
  input wire logic i_bus_err,
  input wire logic i_mem_err,
  input wire logic i_cpu_err,
  input wire logic [31:0] i_err_word,
  input wire logic i_push_ready,
  input wire logic i_wdog_en,
  input wire logic i_wdog_boot,
  output logic o_trace_en,
  output logic o_trace_pend,
  output logic o_stk_t,
  output logic o_stk_tp,
  output logic o_frame_start,
  output tsf_pkg::tsf_frame_t o_frame_kind,
  output logic [7:0] o_vec_offset,
  output logic [1:0] o_vec_low,
  output logic o_use_istk,
  output logic [4:0] o_ipl,
  output logic o_trace_fault,
  output logic o_rei_commit,
  output logic o_mm_fault,
  output logic o_irq_ack,
  output logic o_halted,
  output logic [31:0] o_halt_pc,
  output logic [31:0] o_halt_psl,
  output logic [3:0] o_halt_reason,
  output logic o_mchk_valid,
  output logic [31:0] o_mchk_data,
  output logic o_mchk_last,
  output logic [7:0] o_err_idx
);
  import tsf_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_MCHK, ST_HALT} tsf_state_t;

  tsf_state_t st_r;
  logic t_r;
  logic tp_r;
  logic t_nxt;
  logic tp_nxt;
  logic t_start_r;
  logic mchk_pend_r;
  logic err_any;
  logic run;
  logic take_trace;
  logic take_mchk;
  logic take_rei;
  logic take_chm;
  logic take_irq;
  logic take_exc;
  logic ksnv;
  logic halt_now;
  logic [3:0] halt_reason;

  assign run = (st_r == ST_RUN);
  assign err_any = i_bus_err | i_mem_err | i_cpu_err;
  // Trace fault wins over everything else at the point between instructions.
  assign take_trace = run && tp_r && (i_boundary || i_rei || i_chm);
  assign take_mchk = run && mchk_pend_r && !take_trace;
  assign take_rei = run && i_rei && !tp_r && !take_mchk;
  assign take_chm = run && i_chm && !tp_r && !take_mchk;
  // Interrupts are only acknowledged in the running state, never once halted.
  assign take_irq = run && i_irq_req && i_boundary && !tp_r && !take_mchk
                    && !take_rei && !take_chm && (i_irq_ipl > o_ipl);
  assign take_exc = (run && i_exc_req && !take_trace && !take_mchk && !take_rei
                     && !take_chm) || take_irq;
  assign o_irq_ack = take_irq;
  assign o_trace_en = t_r;
  assign o_trace_pend = tp_r;
  assign o_halted = (st_r == ST_HALT);
  assign ksnv = (st_r == ST_PUSH) && i_push_kstk_inval && !o_use_istk;
  // A memory error aborts either stack; an invalid stack only matters on the stack in use.
  assign halt_now = ((st_r == ST_PUSH) || (st_r == ST_MCHK)) && !ksnv
                    && ((i_push_istk_inval && o_use_istk) || i_push_mem_err);
  assign halt_reason = i_push_mem_err ? TSF_HALT_MEMERR : TSF_HALT_ISNV;

  always_comb begin
    t_nxt = t_r;
    tp_nxt = tp_r;
    if (run) begin
      if (i_instr_end && t_start_r) begin
        tp_nxt = 1'b1;
      end
      if (take_trace || take_mchk || take_exc || take_chm) begin
        t_nxt = 1'b0;
        tp_nxt = 1'b0;
      end else if (take_rei) begin
        // One pending bit covers both the routine and the restored program.
        t_nxt = i_rei_stk_t;
        tp_nxt = i_rei_stk_tp | t_r;
      end else if (i_ret) begin
        t_nxt = i_ret_t;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      t_r <= 1'b0;
      tp_r <= 1'b0;
      t_start_r <= 1'b0;
    end else begin
      t_r <= t_nxt;
      tp_r <= tp_nxt;
      if (i_instr_start) begin
        t_start_r <= t_r;
      end
    end
  end

  // Error pulses are held until taken; a new error in the take cycle is kept.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      mchk_pend_r <= 1'b0;
    end else if (err_any) begin
      mchk_pend_r <= 1'b1;
    end else if (take_mchk) begin
      mchk_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r <= ST_RUN;
    end else begin
      case (st_r)
        ST_RUN: begin
          if (take_mchk) begin
            st_r <= ST_MCHK;
          end else if (take_trace || take_exc || take_chm) begin
            st_r <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (halt_now) begin
            st_r <= ST_HALT;
          end else if (i_push_done && !ksnv) begin
            st_r <= ST_RUN;
          end
        end
        ST_MCHK: begin
          if (halt_now) begin
            st_r <= ST_HALT;
          end else if (o_mchk_last && i_push_ready) begin
            st_r <= ST_RUN;
          end
        end
        ST_HALT: begin
          if (i_wdog_en && i_wdog_boot) begin
            st_r <= ST_RUN;
          end
        end
        default: begin
          st_r <= ST_RUN;
        end
      endcase
    end
  end

  // Frame description handed to the sequencer that pushes the frame.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_stk_t <= 1'b0;
      o_stk_tp <= 1'b0;
      o_frame_start <= 1'b0;
      o_frame_kind <= TSF_FR_NONE;
      o_vec_offset <= 8'h00;
      o_vec_low <= 2'h0;
      o_use_istk <= 1'b0;
      o_trace_fault <= 1'b0;
    end else begin
      o_frame_start <= take_trace || take_mchk || take_exc || take_chm || ksnv;
      o_trace_fault <= take_trace;
      if (take_trace) begin
        o_stk_t <= t_r;
        o_stk_tp <= 1'b0;
        o_frame_kind <= TSF_FR_TRACE;
        o_vec_offset <= TSF_VEC_TRACE;
        o_vec_low <= 2'h0;
        o_use_istk <= i_exc_istk;
      end else if (take_mchk) begin
        o_stk_t <= t_r;
        o_stk_tp <= tp_r;
        o_frame_kind <= TSF_FR_MCHK;
        o_vec_offset <= TSF_VEC_MCHK;
        o_vec_low <= TSF_VEC_LOW_ISTK;
        o_use_istk <= 1'b1;
      end else if (take_chm) begin
        o_stk_t <= t_r;
        o_stk_tp <= t_r;
        o_frame_kind <= TSF_FR_CHM;
        o_vec_offset <= 8'h00;
        o_vec_low <= 2'h0;
        o_use_istk <= i_exc_istk;
      end else if (take_exc) begin
        o_stk_t <= t_r;
        o_stk_tp <= tp_r;
        o_frame_kind <= TSF_FR_EXC;
        o_vec_offset <= 8'h00;
        o_vec_low <= 2'h0;
        o_use_istk <= i_exc_istk;
      end else if (ksnv) begin
        // Only the original PC and status go on the interrupt stack; stacked bits stay.
        o_frame_kind <= TSF_FR_KSNV;
        o_vec_offset <= TSF_VEC_KSNV;
        o_vec_low <= TSF_VEC_LOW_ISTK;
        o_use_istk <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_ipl <= TSF_IPL_RESET;
    end else if (take_mchk || ksnv) begin
      o_ipl <= TSF_IPL_MAX;
    end else if (take_irq) begin
      o_ipl <= i_irq_ipl;
    end else if (take_rei) begin
      o_ipl <= i_rei_ipl;
    end
  end

  // A preempted return never commits its pop, so the original frame is untouched.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rei_commit <= 1'b0;
      o_mm_fault <= 1'b0;
    end else begin
      o_rei_commit <= take_rei;
      o_mm_fault <= run && i_kstk_inval_instr;
    end
  end

  // The frame carries whatever state is at hand; uncertain errors are best effort.
  tsf_mchk_frame #(
    .WORDS(MCHK_WORDS)
  ) u_mchk (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(take_mchk),
    .i_pc(i_pc),
    .i_psl(i_psl),
    .i_err_word(i_err_word),
    .i_ready(i_push_ready),
    .o_valid(o_mchk_valid),
    .o_data(o_mchk_data),
    .o_last(o_mchk_last),
    .o_err_idx(o_err_idx)
  );

  tsf_halt_regs u_halt (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_capture(halt_now),
    .i_pc(i_pc),
    .i_psl(i_psl),
    .i_reason(halt_reason),
    .o_pc(o_halt_pc),
    .o_psl(o_halt_psl),
    .o_reason(o_halt_reason)
  );

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_exc_clears_bits: assert property ((take_exc || take_mchk) |=> (!t_r && !tp_r))
    else $error("trace bits not cleared on exception");
  a_exc_stacks_bits: assert property (take_exc |=> (o_stk_t == $past(t_r)
    && o_stk_tp == $past(tp_r)))
    else $error("stacked trace bits differ from current");
  a_chm_stack_tp: assert property (take_chm |=> (o_stk_tp == $past(t_r) && !tp_r))
    else $error("change-mode stacked pending wrong");
  a_trace_fault_pulse: assert property ((run && tp_r && i_rei) |=> (o_trace_fault
    && !o_stk_tp && !o_rei_commit))
    else $error("pending trace not taken at return");
  a_rei_restore: assert property (take_rei |=> (t_r == $past(i_rei_stk_t)
    && tp_r == ($past(i_rei_stk_tp) | $past(t_r))))
    else $error("return restored wrong trace bits");
  a_ksnv_abort: assert property (ksnv |=> (o_use_istk && o_ipl == TSF_IPL_MAX
    && o_frame_kind == TSF_FR_KSNV))
    else $error("kernel stack abort not on interrupt stack at 1F");
  a_halt_entry: assert property (halt_now |=> (o_halted && o_halt_pc == $past(i_pc)))
    else $error("push failure did not halt");
  a_halt_no_ack: assert property (o_halted |-> !o_irq_ack)
    else $error("interrupt acknowledged while halted");
  a_mchk_count: assert property (take_mchk |=> (o_mchk_valid
    && o_mchk_data == 32'(MCHK_WORDS * TSF_BYTES_PER_WORD)))
    else $error("machine-check count longword wrong");
  a_end_sets_tp: assert property ((run && i_instr_end && t_start_r && !take_trace
    && !take_exc && !take_mchk && !take_chm && !take_rei) |=> tp_r)
    else $error("trace pending not set at instruction end");
  a_trace_first: assert property ((run && tp_r && i_boundary) |-> !take_exc)
    else $error("exception taken ahead of pending trace");

  c_rei_trace: cover property (run && tp_r && i_rei);
  c_ksnv: cover property (ksnv);
  c_mchk_done: cover property (o_mchk_last && i_push_ready);
  c_halt_boot: cover property (o_halted && i_wdog_en && i_wdog_boot);
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking testbench for the trace and severe fault unit.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tsf_pkg::*;
  // A short error report keeps the frame walk brief; the byte count follows from it.
  localparam int NW = 3;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_instr_start = 1'b0, i_instr_end = 1'b0, i_boundary = 1'b0, i_rei = 1'b0;
  logic i_rei_stk_t = 1'b0, i_rei_stk_tp = 1'b0, i_chm = 1'b0, i_ret = 1'b0, i_ret_t = 1'b0;
  logic i_exc_req = 1'b0, i_exc_istk = 1'b0, i_irq_req = 1'b0, i_push_done = 1'b0;
  logic i_push_kstk_inval = 1'b0, i_push_istk_inval = 1'b0, i_push_mem_err = 1'b0;
  logic i_kstk_inval_instr = 1'b0, i_bus_err = 1'b0, i_mem_err = 1'b0, i_cpu_err = 1'b0;
  logic i_push_ready = 1'b1, i_wdog_en = 1'b0, i_wdog_boot = 1'b0;
  logic [4:0] i_rei_ipl = 5'h00, i_irq_ipl = 5'h10;
  logic [31:0] i_pc = 32'h0000_1234, i_psl = 32'h0000_5678, i_err_word;
  logic o_trace_en, o_trace_pend, o_stk_t, o_stk_tp, o_frame_start, o_use_istk, o_trace_fault;
  logic o_rei_commit, o_mm_fault, o_irq_ack, o_halted, o_mchk_valid, o_mchk_last;
  tsf_frame_t o_frame_kind;
  logic [7:0] o_vec_offset, o_err_idx;
  logic [1:0] o_vec_low;
  logic [4:0] o_ipl;
  logic [31:0] o_halt_pc, o_halt_psl, o_mchk_data;
  logic [3:0] o_halt_reason;
  int num_errors = 0;
  int n_tests = 0;

  // Each error word carries its own index so a misplaced word shows up.
  assign i_err_word = {24'hE0_0000, o_err_idx};

  tsf_unit #(.MCHK_WORDS(NW)) dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_instr_start(i_instr_start),
    .i_instr_end(i_instr_end), .i_boundary(i_boundary), .i_rei(i_rei),
    .i_rei_stk_t(i_rei_stk_t), .i_rei_stk_tp(i_rei_stk_tp), .i_rei_ipl(i_rei_ipl),
    .i_chm(i_chm), .i_ret(i_ret), .i_ret_t(i_ret_t), .i_exc_req(i_exc_req),
    .i_exc_istk(i_exc_istk), .i_irq_req(i_irq_req), .i_irq_ipl(i_irq_ipl), .i_pc(i_pc),
    .i_psl(i_psl), .i_push_done(i_push_done), .i_push_kstk_inval(i_push_kstk_inval),
    .i_push_istk_inval(i_push_istk_inval), .i_push_mem_err(i_push_mem_err),
    .i_kstk_inval_instr(i_kstk_inval_instr), .i_bus_err(i_bus_err), .i_mem_err(i_mem_err),
    .i_cpu_err(i_cpu_err), .i_err_word(i_err_word), .i_push_ready(i_push_ready),
    .i_wdog_en(i_wdog_en), .i_wdog_boot(i_wdog_boot), .o_trace_en(o_trace_en),
    .o_trace_pend(o_trace_pend), .o_stk_t(o_stk_t), .o_stk_tp(o_stk_tp),
    .o_frame_start(o_frame_start), .o_frame_kind(o_frame_kind), .o_vec_offset(o_vec_offset),
    .o_vec_low(o_vec_low), .o_use_istk(o_use_istk), .o_ipl(o_ipl),
    .o_trace_fault(o_trace_fault), .o_rei_commit(o_rei_commit), .o_mm_fault(o_mm_fault),
    .o_irq_ack(o_irq_ack), .o_halted(o_halted), .o_halt_pc(o_halt_pc),
    .o_halt_psl(o_halt_psl), .o_halt_reason(o_halt_reason), .o_mchk_valid(o_mchk_valid),
    .o_mchk_data(o_mchk_data), .o_mchk_last(o_mchk_last), .o_err_idx(o_err_idx)
  );

  always #10 i_clk = ~i_clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic step;
    @(posedge i_clk);
    #1;
  endtask

  task automatic tt(input logic t, input logic tp);
    chk("trace_en", o_trace_en, t);
    chk("trace_pend", o_trace_pend, tp);
  endtask

  task automatic frm(input tsf_frame_t k, input logic st, input logic stp);
    chk("frame_start", o_frame_start, 1'b1);
    chk("frame_kind", o_frame_kind, k);
    chk("stk_t", o_stk_t, st);
    chk("stk_tp", o_stk_tp, stp);
  endtask

  task automatic return_from_exception(input logic t, input logic tp, input logic [4:0] priority_level);
    i_rei = 1'b1;
    i_rei_stk_t = t;
    i_rei_stk_tp = tp;
    i_rei_ipl = priority_level;
    step;
    i_rei = 1'b0;
  endtask

  task automatic done;
    i_push_done = 1'b1;
    step;
    i_push_done = 0;
    step;
  endtask

  task automatic t_rei;
    return_from_exception(1'b1, 1'b0, 5'h00);
    tt(1'b1, 1'b0);
    chk("rei_commit", o_rei_commit, 1'b1);
    step;
    return_from_exception(1'b1, 1'b0, 5'h00);
    tt(1'b1, 1'b1);
    step;
    return_from_exception(1'b0, 1'b1, 5'h00);
    chk("trace_fault", o_trace_fault, 1'b1);
    chk("rei_commit", o_rei_commit, 1'b0);
    frm(TSF_FR_TRACE, 1'b1, 1'b0);
    chk("vec", o_vec_offset, TSF_VEC_TRACE);
    tt(1'b0, 1'b0);
    done;
    return_from_exception(1'b1, 1'b0, 5'h00);
    step;
    return_from_exception(1'b1, 1'b0, 5'h00);
    i_boundary = 1'b1;
    step;
    i_boundary = 1'b0;
    frm(TSF_FR_TRACE, 1'b1, 1'b0);
    done;
    i_boundary = 1'b1;
    step;
    i_boundary = 1'b0;
    chk("second trace", o_trace_fault, 1'b0);
  endtask

  task automatic t_chm_exc;
    return_from_exception(1'b1, 1'b0, 5'h00);
    i_chm = 1'b1;
    step;
    i_chm = 1'b0;
    frm(TSF_FR_CHM, 1'b1, 1'b1);
    tt(1'b0, 1'b0);
    done;
    return_from_exception(1'b1, 1'b0, 5'h00);
    i_exc_req = 1'b1;
    step;
    i_exc_req = 1'b0;
    frm(TSF_FR_EXC, 1'b1, 1'b0);
    tt(1'b0, 1'b0);
    done;
    return_from_exception(1'b1, 1'b0, 5'h00);
    i_instr_start = 1'b1;
    step;
    i_instr_start = 1'b0;
    i_instr_end = 1'b1;
    step;
    i_instr_end = 1'b0;
    tt(1'b1, 1'b1);
    i_boundary = 1'b1;
    i_exc_req = 1'b1;
    step;
    i_boundary = 1'b0;
    i_exc_req = 1'b0;
    frm(TSF_FR_TRACE, 1'b1, 1'b0);
    done;
  endtask

  task automatic t_ret;
    i_ret = 1'b1;
    i_ret_t = 1'b1;
    step;
    i_ret = 1'b0;
    tt(1'b1, 1'b0);
    i_instr_start = 1'b1;
    step;
    i_instr_start = 1'b0;
    i_instr_end = 1'b1;
    step;
    i_instr_end = 1'b0;
    tt(1'b1, 1'b1);
    return_from_exception(1'b0, 1'b0, 5'h00);
    done;
  endtask

  task automatic t_kstk;
    return_from_exception(1'b0, 1'b0, 5'h00);
    i_exc_req = 1'b1;
    step;
    i_exc_req = 1'b0;
    i_push_kstk_inval = 1'b1;
    step;
    i_push_kstk_inval = 1'b0;
    frm(TSF_FR_KSNV, 1'b0, 1'b0);
    chk("istk", o_use_istk, 1'b1);
    chk("ipl", o_ipl, TSF_IPL_MAX);
    chk("vec", o_vec_offset, TSF_VEC_KSNV);
    chk("vec_low", o_vec_low, TSF_VEC_LOW_ISTK);
    done;
    i_kstk_inval_instr = 1'b1;
    step;
    i_kstk_inval_instr = 1'b0;
    chk("mm_fault", o_mm_fault, 1'b1);
    chk("no frame", o_frame_start, 1'b0);
  endtask

  task automatic t_halt;
    for (int r = 0; r < 2; r++) begin
      return_from_exception(1'b0, 1'b0, 5'h00);
      i_irq_req = 1'b1;
      i_boundary = 1'b1;
      #1;
      chk("ack run", o_irq_ack, 1'b1);
      step;
      i_irq_req = 1'b0;
      i_boundary = 1'b0;
      done;
      i_exc_req = 1'b1;
      i_exc_istk = 1'b1;
      step;
      i_exc_req = 1'b0;
      chk("istk", o_use_istk, 1'b1);
      i_pc = 32'hA000_0010 + r;
      i_psl = 32'h0B00_0020 + r;
      i_push_istk_inval = (r == 0);
      i_push_mem_err = (r == 1);
      step;
      i_push_istk_inval = 1'b0;
      i_push_mem_err = 1'b0;
      i_exc_istk = 1'b0;
      chk("halted", o_halted, 1'b1);
      chk("halt_pc", o_halt_pc, 32'hA000_0010 + r);
      chk("halt_psl", o_halt_psl, 32'h0B00_0020 + r);
      chk("reason", o_halt_reason, (r == 0) ? TSF_HALT_ISNV : TSF_HALT_MEMERR);
      i_irq_req = 1'b1;
      i_boundary = 1'b1;
      i_wdog_boot = 1'b1;
      for (int k = 0; k < 4; k++) begin
        chk("ack halted", o_irq_ack, 1'b0);
        step;
      end
      i_irq_req = 1'b0;
      i_boundary = 1'b0;
      chk("boot off", o_halted, 1'b1);
      i_wdog_en = 1'b1;
      i_wdog_boot = 1'b1;
      step;
      i_wdog_boot = 1'b0;
      i_wdog_en = 1'b0;
      chk("boot", o_halted, 1'b0);
    end
  endtask

  task automatic t_mchk;
    logic [31:0] exp;
    for (int e = 0; e < 3; e++) begin
      return_from_exception(1'b0, 1'b0, 5'h1F);
      i_pc = 32'h0000_4400 + e;
      i_psl = 32'h0000_8800 + e;
      i_bus_err = (e == 0);
      i_mem_err = (e == 1);
      i_cpu_err = (e == 2);
      step;
      i_bus_err = 1'b0;
      i_mem_err = 1'b0;
      i_cpu_err = 1'b0;
      for (int w = 0; w < 8 && o_mchk_valid !== 1'b1; w++) step;
      chk("mchk kind", o_frame_kind, TSF_FR_MCHK);
      chk("istk", o_use_istk, 1'b1);
      chk("ipl", o_ipl, TSF_IPL_MAX);
      chk("vec", o_vec_offset, TSF_VEC_MCHK);
      chk("vec_low", o_vec_low, TSF_VEC_LOW_ISTK);
      for (int k = 0; k < NW + 3; k++) begin
        if (k == 0) exp = NW * TSF_BYTES_PER_WORD;
        else if (k <= NW) exp = {24'hE0_0000, 8'(k - 1)};
        else if (k == NW + 1) exp = 32'h0000_4400 + e;
        else exp = 32'h0000_8800 + e;
        // One stalled cycle checks that a word is held until accepted.
        i_push_ready = (k != 1);
        chk("mchk valid", o_mchk_valid, 1'b1);
        chk("mchk data", o_mchk_data, exp);
        chk("mchk last", o_mchk_last, k == NW + 2);
        step;
        if (k == 1) begin
          chk("mchk held", o_mchk_data, exp);
          i_push_ready = 1'b1;
          step;
        end
      end
      done;
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    tt(1'b0, 1'b0);
    chk("ipl reset", o_ipl, TSF_IPL_RESET);
    chk("halted reset", o_halted, 1'b0);
    t_rei;
    t_chm_exc;
    t_ret;
    t_kstk;
    t_halt;
    t_mchk;
    close_out;
  end

  // Whole run is just over a hundred cycles; this bound only catches a hang.
  initial begin
    repeat (3000) @(posedge i_clk);
    num_errors++;
    close_out;
  end
endmodule
`default_nettype wire
